// >>> hdl/ptm_defines.svh
// Register offsets, field positions, reset values and constants of the periodic timer
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH

`define PTM_OFS_CTRL     12'h000
`define PTM_OFS_CMPA     12'h004
`define PTM_OFS_PERIOD   12'h008
`define PTM_OFS_COUNT    12'h00C
`define PTM_OFS_FLAGS    12'h010

`define PTM_CTRL_MODE_LO 0
`define PTM_CTRL_ACT_LO  2
`define PTM_CTRL_RUN     4
`define PTM_CTRL_OLC     5
`define PTM_CTRL_INV     6
`define PTM_CTRL_CSRC    7
`define PTM_CTRL_CCLR    8
`define PTM_CTRL_W       9

`define PTM_FLAG_A       0
`define PTM_FLAG_P       1

`define PTM_CTRL_RST     9'h000
`define PTM_VAL_RST      10'h000
`define PTM_CNT_MAX      10'h3FF

`define PTM_RESP_OKAY    2'h0
`define PTM_RESP_SLVERR  2'h2

`endif

// >>> hdl/ptm_pkg.sv
// Types shared by the periodic timer
package ptm_pkg;

   typedef enum logic [1:0] {
      PTM_MODE_CMP  = 2'h0,
      PTM_MODE_CAP  = 2'h1,
      PTM_MODE_PWM  = 2'h2,
      PTM_MODE_TMR  = 2'h3
   } ptm_mode_e;

   typedef enum logic [1:0] {
      PTM_ACT_NONE  = 2'h0,
      PTM_ACT_LOW   = 2'h1,
      PTM_ACT_HIGH  = 2'h2,
      PTM_ACT_TOGL  = 2'h3
   } ptm_act_e;

endpackage : ptm_pkg

// >>> hdl/ptm_timer.sv
// Periodic 10-bit timer with compare, PWM, single pulse and capture modes over AXI4-Lite
`include "ptm_defines.svh"

module ptm_timer
   import ptm_pkg::*;
#(
   parameter int CNT_W = 10
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic [11:0] i_s_axi_awaddr,
   input  wire logic        i_s_axi_awvalid,
   output logic             o_s_axi_awready,
   input  wire logic [31:0] i_s_axi_wdata,
   input  wire logic [3:0]  i_s_axi_wstrb,
   input  wire logic        i_s_axi_wvalid,
   output logic             o_s_axi_wready,
   output logic [1:0]       o_s_axi_bresp,
   output logic             o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   input  wire logic [11:0] i_s_axi_araddr,
   input  wire logic        i_s_axi_arvalid,
   output logic             o_s_axi_arready,
   output logic [31:0]      o_s_axi_rdata,
   output logic [1:0]       o_s_axi_rresp,
   output logic             o_s_axi_rvalid,
   input  wire logic        i_s_axi_rready,
   input  wire logic        i_ext_clock_pin,
   input  wire logic        i_capture_input_pin,
   output logic             o_timer_pin,
   output logic             o_timer_pin_oe,
   output logic             o_match_a_flag,
   output logic             o_match_p_flag
);

   // Merge byte lanes of a write into a register image
   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : apply_strb
   function automatic logic addr_known(input logic [11:0] a);
      return (a == `PTM_OFS_CTRL) || (a == `PTM_OFS_CMPA) || (a == `PTM_OFS_PERIOD) ||
             (a == `PTM_OFS_COUNT) || (a == `PTM_OFS_FLAGS);
   endfunction : addr_known

   // Bus state
   logic              aw_held_q;
   logic [11:0]       awaddr_q;
   logic              w_held_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [31:0]       rdata_q;
   logic              wr_fire;
   // Timer state
   logic [`PTM_CTRL_W-1:0] ctrl_q;
   logic [CNT_W-1:0]  cmpa_q;
   logic [CNT_W-1:0]  period_q;
   logic [CNT_W-1:0]  cnt_q;
   logic              flag_a_q;
   logic              flag_p_q;
   logic              run_prev_q;
   logic              ext_prev_q;
   logic              cap_prev_q;
   logic              cmp_out_q;
   logic              pin_q;
   logic              pin_oe_q;
   ptm_mode_e         mode;
   ptm_act_e          act;
   logic              run;
   logic              run_rise;
   logic              a_hit;
   logic              p_hit;
   logic              cnt_clear;
   logic              set_a;
   logic              set_p;
   logic              sp_mode;
   logic              sp_end;
   logic              ext_rise;
   logic              cap_src;
   logic              cap_prev_src;
   logic              cap_evt;
   logic [CNT_W:0]    period_eff;
   logic              pwm_active;
   logic [31:0]       ctrl_wr;
   logic              wr_ctrl;
   logic              wr_cmpa;
   logic              wr_period;
   logic              wr_flags;
   logic              pin_d;

   assign mode     = ptm_mode_e'(ctrl_q[`PTM_CTRL_MODE_LO +: 2]);
   assign act      = ptm_act_e'(ctrl_q[`PTM_CTRL_ACT_LO +: 2]);
   assign run      = ctrl_q[`PTM_CTRL_RUN];
   assign run_rise = run & ~run_prev_q;
   assign sp_mode  = (mode == PTM_MODE_PWM) && (act == PTM_ACT_TOGL);
   assign o_s_axi_awready = ~aw_held_q & ~bvalid_q;
   assign o_s_axi_wready  = ~w_held_q & ~bvalid_q;
   assign o_s_axi_bvalid  = bvalid_q;
   assign o_s_axi_bresp   = bresp_q;
   assign wr_fire         = aw_held_q & w_held_q & ~bvalid_q;
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= 12'h000;
      end else if (o_s_axi_awready && i_s_axi_awvalid) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= i_s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         w_held_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (o_s_axi_wready && i_s_axi_wvalid) begin
         w_held_q <= 1'b1;
         wdata_q  <= i_s_axi_wdata;
         wstrb_q  <= i_s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `PTM_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= addr_known(awaddr_q) ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
      end else if (i_s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign wr_ctrl   = wr_fire && (awaddr_q == `PTM_OFS_CTRL);
   assign wr_cmpa   = wr_fire && (awaddr_q == `PTM_OFS_CMPA);
   assign wr_period = wr_fire && (awaddr_q == `PTM_OFS_PERIOD);
   assign wr_flags  = wr_fire && (awaddr_q == `PTM_OFS_FLAGS);
   assign ctrl_wr   = apply_strb({23'h000000, ctrl_q}, wdata_q, wstrb_q);
   assign o_s_axi_arready = ~rvalid_q;
   assign o_s_axi_rvalid  = rvalid_q;
   assign o_s_axi_rresp   = rresp_q;
   assign o_s_axi_rdata   = rdata_q;
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rvalid_q <= 1'b0;
         rresp_q  <= `PTM_RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else if (o_s_axi_arready && i_s_axi_arvalid) begin
         rvalid_q <= 1'b1;
         rresp_q  <= addr_known(i_s_axi_araddr) ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
         unique case (i_s_axi_araddr)
            `PTM_OFS_CTRL:   rdata_q <= {23'h000000, ctrl_q};
            `PTM_OFS_CMPA:   rdata_q <= {22'h000000, cmpa_q};
            `PTM_OFS_PERIOD: rdata_q <= {22'h000000, period_q};
            `PTM_OFS_COUNT:  rdata_q <= {22'h000000, cnt_q};
            `PTM_OFS_FLAGS:  rdata_q <= {30'h00000000, flag_p_q, flag_a_q};
            default:         rdata_q <= 32'h0000_0000;
         endcase
      end else if (i_s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign period_eff = (period_q == '0) ? (CNT_W+1)'(1 << CNT_W)
                                        : {1'b0, period_q};
   assign p_hit      = run & ~run_rise &
                       ({1'b0, cnt_q} == period_eff - (CNT_W+1)'(1));
   // Zero compare value never matches in the compare and timer modes
   assign a_hit      = run & ~run_rise & (cnt_q == cmpa_q) &
                       ~(((mode == PTM_MODE_CMP) || (mode == PTM_MODE_TMR)) &&
                         (cmpa_q == '0));
   assign sp_end     = sp_mode & a_hit;
   assign ext_rise   = i_ext_clock_pin & ~ext_prev_q;
   assign cap_src      = ctrl_q[`PTM_CTRL_CSRC] ? i_ext_clock_pin : i_capture_input_pin;
   assign cap_prev_src = ctrl_q[`PTM_CTRL_CSRC] ? ext_prev_q : cap_prev_q;
   always_comb begin
      cap_evt = 1'b0;
      unique case (act)
         PTM_ACT_NONE: cap_evt = cap_src & ~cap_prev_src;
         PTM_ACT_LOW:  cap_evt = ~cap_src & cap_prev_src;
         PTM_ACT_HIGH: cap_evt = cap_src ^ cap_prev_src;
         PTM_ACT_TOGL: cap_evt = 1'b0;
      endcase
      cap_evt = cap_evt & run & (mode == PTM_MODE_CAP);
   end

   always_comb begin
      cnt_clear = 1'b0;
      set_a     = 1'b0;
      set_p     = 1'b0;
      unique case (mode)
         PTM_MODE_CMP, PTM_MODE_TMR: begin
            cnt_clear = ctrl_q[`PTM_CTRL_CCLR] ? a_hit : p_hit;
            set_a     = a_hit;
            set_p     = p_hit & ~ctrl_q[`PTM_CTRL_CCLR];
         end
         PTM_MODE_PWM: begin
            cnt_clear = sp_mode ? 1'b0 : p_hit;
            set_a     = a_hit;
            set_p     = sp_mode ? 1'b0 : p_hit;
         end
         PTM_MODE_CAP: begin
            cnt_clear = p_hit;
            set_a     = cap_evt;
            set_p     = p_hit;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ctrl_q <= `PTM_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_wr[`PTM_CTRL_W-1:0];
      end else if (sp_end) begin
         ctrl_q[`PTM_CTRL_RUN] <= 1'b0;
      end else if (sp_mode && ext_rise) begin
         ctrl_q[`PTM_CTRL_RUN] <= 1'b1;
      end
   end
   // Capture wins over a software write in the same cycle
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cmpa_q <= `PTM_VAL_RST;
      end else if (cap_evt) begin
         cmpa_q <= cnt_q;
      end else if (wr_cmpa) begin
         cmpa_q <= CNT_W'(apply_strb({22'h000000, cmpa_q}, wdata_q, wstrb_q));
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         period_q <= `PTM_VAL_RST;
      end else if (wr_period) begin
         period_q <= CNT_W'(apply_strb({22'h000000, period_q}, wdata_q, wstrb_q));
      end
   end
   // Sticky flags, write one to clear, a new event wins over the clear
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         flag_a_q <= 1'b0;
         flag_p_q <= 1'b0;
      end else begin
         flag_a_q <= set_a |
                     (flag_a_q & ~(wr_flags & wstrb_q[0] & wdata_q[`PTM_FLAG_A]));
         flag_p_q <= set_p |
                     (flag_p_q & ~(wr_flags & wstrb_q[0] & wdata_q[`PTM_FLAG_P]));
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= `PTM_VAL_RST;
      end else if (run_rise) begin
         cnt_q <= '0;
      end else if (run) begin
         cnt_q <= cnt_clear ? '0 : cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         run_prev_q <= 1'b0;
         ext_prev_q <= 1'b0;
         cap_prev_q <= 1'b0;
      end else begin
         run_prev_q <= run;
         ext_prev_q <= i_ext_clock_pin;
         cap_prev_q <= i_capture_input_pin;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cmp_out_q <= 1'b0;
      end else if (run_rise) begin
         cmp_out_q <= ctrl_q[`PTM_CTRL_OLC];
      end else if (mode == PTM_MODE_CMP && set_a) begin
         unique case (act)
            PTM_ACT_NONE: cmp_out_q <= cmp_out_q;
            PTM_ACT_LOW:  cmp_out_q <= 1'b0;
            PTM_ACT_HIGH: cmp_out_q <= 1'b1;
            PTM_ACT_TOGL: cmp_out_q <= ~cmp_out_q;
         endcase
      end
   end

   assign pwm_active = ({1'b0, cmpa_q} >= period_eff) ||
                       ({1'b0, cnt_q} < {1'b0, cmpa_q});
   always_comb begin
      pin_d = 1'b0;
      unique case (act)
         PTM_ACT_NONE: pin_d = ~ctrl_q[`PTM_CTRL_OLC];
         PTM_ACT_LOW:  pin_d = ctrl_q[`PTM_CTRL_OLC];
         PTM_ACT_HIGH: pin_d = (run & pwm_active) ? ctrl_q[`PTM_CTRL_OLC]
                                                  : ~ctrl_q[`PTM_CTRL_OLC];
         PTM_ACT_TOGL: pin_d = run ? ctrl_q[`PTM_CTRL_OLC]
                                   : ~ctrl_q[`PTM_CTRL_OLC];
      endcase
      if (mode == PTM_MODE_CMP) begin
         pin_d = cmp_out_q;
      end
      pin_d = pin_d ^ ctrl_q[`PTM_CTRL_INV];
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pin_q    <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         pin_q    <= pin_d;
         pin_oe_q <= (mode == PTM_MODE_CMP) || (mode == PTM_MODE_PWM);
      end
   end
   assign o_timer_pin    = pin_q;
   assign o_timer_pin_oe = pin_oe_q;
   assign o_match_a_flag = flag_a_q;
   assign o_match_p_flag = flag_p_q;
endmodule : ptm_timer

// >>> tb/ptm_timer_checker.sv
// Bus handshake and flag checks on the periodic timer ports
`include "ptm_defines.svh"
module ptm_timer_checker #(
   parameter int CNT_W = 10
) (
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic        i_s_axi_awvalid,
   input wire logic        o_s_axi_awready,
   input wire logic        i_s_axi_wvalid,
   input wire logic        o_s_axi_wready,
   input wire logic [1:0]  o_s_axi_bresp,
   input wire logic        o_s_axi_bvalid,
   input wire logic        i_s_axi_bready,
   input wire logic        i_s_axi_arvalid,
   input wire logic        o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic [1:0]  o_s_axi_rresp,
   input wire logic        o_s_axi_rvalid,
   input wire logic        i_s_axi_rready,
   input wire logic        o_match_a_flag,
   input wire logic        o_match_p_flag
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   sequence s_wr_taken;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
   endsequence
   sequence s_b_rise;
      !o_s_axi_bvalid ##1 o_s_axi_bvalid;
   endsequence
   property p_wr_resp;
      s_wr_taken |=> s_b_rise;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
   property p_rd_resp;
      i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
   property p_b_hold;
      o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_r_block;
      o_s_axi_rvalid |-> !o_s_axi_arready;
   endproperty
   a_r_block: assert property (p_r_block) else $error("read taken while busy");
   property p_b_block;
      o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
   endproperty
   a_b_block: assert property (p_b_block) else $error("write taken while busy");
   property p_err_zero;
      o_s_axi_rvalid && o_s_axi_rresp == `PTM_RESP_SLVERR |-> o_s_axi_rdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   property p_flag_clear;
      $fell(o_match_a_flag) || $fell(o_match_p_flag) |-> $rose(o_s_axi_bvalid);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag lost");
endmodule : ptm_timer_checker

bind ptm_timer ptm_timer_checker #(.CNT_W(CNT_W)) u_ptm_timer_checker (
   .i_clock(i_clock), .i_rst(i_rst),
   .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
   .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
   .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
   .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
   .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
   .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
   .i_s_axi_rready(i_s_axi_rready), .o_match_a_flag(o_match_a_flag),
   .o_match_p_flag(o_match_p_flag)
);

// >>> tb/tb_top.sv
// Self-checking bench for the periodic timer
`include "ptm_defines.svh"
module tb_top import ptm_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic        ext = 0, cap = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd, c1;
   logic [1:0]  rr;
   wire         awr, wrd, arr, bv, rv, pin, oe, fa, fp;
   wire [1:0]   br, rrs;
   wire [31:0]  rdt;
   int          fails = 0, check_count = 0, n;

   always #10 clk = ~clk;

   ptm_timer u_ptm_timer (
      .i_clock(clk), .i_rst(rst), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
      .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
      .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .o_s_axi_bresp(br),
      .o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .i_s_axi_araddr(ara),
      .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdt),
      .o_s_axi_rresp(rrs), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre),
      .i_ext_clock_pin(ext), .i_capture_input_pin(cap), .o_timer_pin(pin),
      .o_timer_pin_oe(oe), .o_match_a_flag(fa), .o_match_p_flag(fp)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk1

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrd) wv <= 1'b0;
      end while (!bv);
      rr = br;
      bre <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rdr(input logic [11:0] a);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      rd = rdt;
      rr = rrs;
      rre <= 1'b0;
      @(posedge clk);
   endtask : rdr

   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] a,
      input logic r, input logic o, input logic v, input logic c, input logic k);
      return {23'h0, k, c, v, o, r, a, m};
   endfunction : ctl

   task automatic setup(input logic [31:0] a, input logic [31:0] p);
      wr(`PTM_OFS_CTRL, 32'h0);
      wr(`PTM_OFS_FLAGS, 32'h3);
      wr(`PTM_OFS_CMPA, a);
      wr(`PTM_OFS_PERIOD, p);
   endtask : setup

   // Compare mode, counter cleared by comparator A every six clocks
   task automatic cmpt(input logic [1:0] a, input logic o, input int chg);
      logic l;
      setup(32'h5, 32'h3);
      wr(`PTM_OFS_CTRL, ctl(PTM_MODE_CMP, a, 1'b1, o, 1'b0, 1'b0, 1'b1));
      @(posedge clk);
      chk1(pin, o);
      repeat (20) @(posedge clk);
      n = 0;
      l = pin;
      repeat (60) begin
         @(posedge clk);
         n += int'(pin !== l);
         l = pin;
      end
      chk(32'(n), 32'(chg));
      if (chg == 0) chk1(pin, (a == 2'h0) ? o : a[1]);
      rdr(`PTM_OFS_FLAGS);
      chk(rd, 32'h1);
      chk({30'h0, fp, fa}, 32'h1);
   endtask : cmpt

   // High time of the pin over four whole periods
   task automatic pwm(input logic [1:0] act, input logic o, input logic v, input logic k,
      input logic [31:0] a, input logic [31:0] p, input int hi, input logic [31:0] f);
      int np;
      np = (p == 0) ? 1024 : int'(p);
      setup(a, p);
      wr(`PTM_OFS_CTRL, ctl(PTM_MODE_PWM, act, 1'b1, o, v, 1'b0, k));
      repeat (2 * np) @(posedge clk);
      n = 0;
      repeat (4 * np) begin
         @(posedge clk);
         n += int'(pin === 1'b1);
      end
      chk(32'(n), 32'(hi));
      rdr(`PTM_OFS_FLAGS);
      chk(rd, f);
      chk({30'h0, fp, fa}, f);
   endtask : pwm

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         rdr(12'(4 * i));
         chk(rd, 32'h0);
         chk({30'h0, rr}, {30'h0, `PTM_RESP_OKAY});
      end
      rdr(12'h020);
      chk({30'h0, rr}, {30'h0, `PTM_RESP_SLVERR});
      wr(12'h020, 32'h1);
      chk({30'h0, rr}, {30'h0, `PTM_RESP_SLVERR});
      cmpt(PTM_ACT_NONE, 1'b0, 0);
      cmpt(PTM_ACT_LOW, 1'b1, 0);
      cmpt(PTM_ACT_HIGH, 1'b0, 0);
      cmpt(PTM_ACT_TOGL, 1'b0, 10);
      setup(32'h2, 32'h4);
      wr(`PTM_OFS_CTRL, ctl(PTM_MODE_TMR, PTM_ACT_HIGH, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
      repeat (20) @(posedge clk);
      chk1(oe, 1'b0);
      rdr(`PTM_OFS_FLAGS);
      chk(rd, 32'h3);
      pwm(PTM_ACT_HIGH, 1'b1, 1'b0, 1'b0, 32'h1, 32'h4, 4, 32'h3);
      pwm(PTM_ACT_HIGH, 1'b1, 1'b0, 1'b1, 32'h1, 32'h4, 4, 32'h3);
      pwm(PTM_ACT_HIGH, 1'b1, 1'b0, 1'b0, 32'h4, 32'h4, 16, 32'h2);
      pwm(PTM_ACT_HIGH, 1'b1, 1'b0, 1'b0, 32'h6, 32'h4, 16, 32'h2);
      pwm(PTM_ACT_HIGH, 1'b1, 1'b1, 1'b0, 32'h1, 32'h4, 12, 32'h3);
      pwm(PTM_ACT_HIGH, 1'b0, 1'b0, 1'b0, 32'h1, 32'h4, 12, 32'h3);
      pwm(PTM_ACT_LOW, 1'b1, 1'b0, 1'b0, 32'h1, 32'h4, 16, 32'h3);
      pwm(PTM_ACT_NONE, 1'b1, 1'b0, 1'b0, 32'h1, 32'h4, 0, 32'h3);
      pwm(PTM_ACT_HIGH, 1'b1, 1'b0, 1'b0, 32'h1, 32'h0, 4, 32'h3);
      setup(32'd200, 32'h0);
      wr(`PTM_OFS_CTRL, ctl(PTM_MODE_PWM, PTM_ACT_TOGL, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
      repeat (20) @(posedge clk);
      chk1(pin, 1'b1);
      wr(`PTM_OFS_CTRL, ctl(PTM_MODE_PWM, PTM_ACT_TOGL, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
      chk1(pin, 1'b0);
      wr(`PTM_OFS_CMPA, 32'h6);
      ext <= 1'b1;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         n += int'(pin === 1'b1);
      end
      ext <= 1'b0;
      chk1(n >= 6 && n <= 8, 1'b1);
      rdr(`PTM_OFS_CTRL);
      chk1(rd[`PTM_CTRL_RUN], 1'b0);
      rdr(`PTM_OFS_FLAGS);
      chk1(rd[`PTM_FLAG_A], 1'b1);
      setup(32'h0, 32'h0);
      wr(`PTM_OFS_CTRL, ctl(PTM_MODE_CAP, PTM_ACT_NONE, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1));
      chk1(oe, 1'b0);
      repeat (10) @(posedge clk);
      rdr(`PTM_OFS_COUNT);
      c1 = rd;
      cap <= 1'b1;
      repeat (3) @(posedge clk);
      rdr(`PTM_OFS_CMPA);
      chk1(rd > c1 && rd < c1 + 10, 1'b1);
      for (int k = 0; k < 4; k++) begin
         wr(`PTM_OFS_CTRL, ctl(PTM_MODE_CAP, 2'(k), 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
         wr(`PTM_OFS_FLAGS, 32'h3);
         cap <= 1'b0;
         repeat (4) @(posedge clk);
         rdr(`PTM_OFS_FLAGS);
         chk1(rd[`PTM_FLAG_A], k == 1 || k == 2);
         wr(`PTM_OFS_FLAGS, 32'h3);
         cap <= 1'b1;
         repeat (4) @(posedge clk);
         rdr(`PTM_OFS_FLAGS);
         chk1(rd[`PTM_FLAG_A], k == 0 || k == 2);
      end
      rdr(`PTM_OFS_COUNT);
      c1 = rd;
      rdr(`PTM_OFS_COUNT);
      chk1(rd != c1, 1'b1);
      wr(`PTM_OFS_CTRL, ctl(PTM_MODE_CAP, PTM_ACT_NONE, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
      wr(`PTM_OFS_FLAGS, 32'h3);
      cap <= 1'b0;
      repeat (2) @(posedge clk);
      cap <= 1'b1;
      repeat (4) @(posedge clk);
      rdr(`PTM_OFS_FLAGS);
      chk1(rd[`PTM_FLAG_A], 1'b0);
      ext <= 1'b1;
      repeat (4) @(posedge clk);
      rdr(`PTM_OFS_FLAGS);
      chk1(rd[`PTM_FLAG_A], 1'b1);
      setup(32'h0, 32'h5);
      wr(`PTM_OFS_CTRL, ctl(PTM_MODE_CAP, PTM_ACT_TOGL, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
      repeat (10) @(posedge clk);
      rdr(`PTM_OFS_FLAGS);
      chk1(rd[`PTM_FLAG_P], 1'b1);
      rdr(`PTM_OFS_COUNT);
      chk1(rd < 5, 1'b1);
      wr(`PTM_OFS_CTRL, 32'h0);
      rdr(`PTM_OFS_COUNT);
      c1 = rd;
      rdr(`PTM_OFS_COUNT);
      chk(rd, c1);
      stop_test();
   end

   // Hang guard well beyond the longest expected run
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      stop_test();
   end
endmodule : tb_top
